// >>> bench/ring_assist_checker.sv
// Port level checks of the ring assist block
`timescale 1ns/1ps
module ring_assist_checker (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_flush_irq,
    input wire logic o_update_busy,
    input wire logic o_flush_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic [15:0] ub_q, ub_d, fb_q, fb_d;
    logic ctrl_wr;
    assign ctrl_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h00;
    always_comb begin
        ub_d = o_update_busy ? ub_q + 16'h1 : 16'h0;
        fb_d = o_flush_busy ? fb_q + 16'h1 : 16'h0;
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ub_q <= 16'h0;
            fb_q <= 16'h0;
        end else begin
            ub_q <= ub_d;
            fb_q <= fb_d;
        end
    end
    a_ready_setup: assert property ((i_psel && !i_penable) |=> o_pready)
        else $error("no ready in first access cycle");
    a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready too long");
    a_ready_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    a_err_unmapped: assert property ((i_psel && !i_penable && i_paddr == 8'h2c)
        |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
    a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("stray data");
    a_update_len: assert property (o_update_busy |-> ub_q < 16'd4098)
        else $error("update sweep too long");
    a_flush_len: assert property (o_flush_busy |-> fb_q < 16'd260)
        else $error("flush scan too long");
    a_go_starts: assert property ((ctrl_wr && i_pwdata[0] && !o_update_busy)
        |-> ##[1:2] o_update_busy) else $error("update did not start");
    a_trig_starts: assert property ((ctrl_wr && i_pwdata[2] && !o_flush_busy)
        |-> ##[1:2] o_flush_busy) else $error("flush did not start");
    a_irq_after: assert property ($rose(o_flush_irq) |-> !o_flush_busy)
        else $error("interrupt while flushing");
endmodule
bind ring_assist ring_assist_checker ring_assist_checker_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_flush_irq(o_flush_irq), .o_update_busy(o_update_busy), .o_flush_busy(o_flush_busy));

// >>> bench/ring_assist_tb.sv
// Self-checking bench for the ring assist block against a table model
`timescale 1ns/1ps
module ring_assist_tb;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata, rd;
    logic o_pready, o_pslverr, o_flush_irq, o_update_busy, o_flush_busy, err;
    int miscompares = 0, n_tests = 0, cyc = 0, found;
    int unsigned rs = 18279;
    int grp[64], mem[64], mv[256], mp[256], mf[256], lst[16];
    always #20 i_mclk = ~i_mclk;
    ring_assist ring_assist_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_flush_irq(o_flush_irq), .o_update_busy(o_update_busy), .o_flush_busy(o_flush_busy));
    function automatic int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic wt(input bit f);
        repeat (2) @(posedge i_mclk);
        chk("busy", 1, f ? o_flush_busy : o_update_busy);
        // Only the cycle ceiling ends a hung engine
        while ((f ? o_flush_busy : o_update_busy) !== 1'b0)
            @(posedge i_mclk);
    endtask
    // Reference sweep and scan, written from the rules
    task automatic run(input int c, input int f0, input int f1, input int gm, input int one);
        for (int v = f0; v <= f1; v++)
            if (!c[1] || (grp[v] & gm) != 0 || (mem[v] & 'h400) != 0) mem[v] |= 'h100;
        found = 0;
        for (int i = 0; i < 256; i++) begin
            bit hit = (one != 'h1ffff && mf[i] == one);
            foreach (lst[j]) hit |= c[3] && lst[j] != 'h1ffff && lst[j] == mf[i];
            if (mv[i] && (!c[4] || hit) && (!c[5] || (mp[i] < 11 && mp[i] inside {7, 8}))) begin
                found++;
                if (c[6]) mv[i] = 0;
            end
        end
    endtask
    task automatic check_all();
        for (int v = 0; v < 64; v++) begin
            apb(1'b1, ring_assist_pkg::VLAN_IDX_OFS, 32'(v));
            apb(1'b0, ring_assist_pkg::VLAN_DATA0_OFS, 32'h0);
            chk("vlan entry", 32'((mem[v] << 16) | grp[v]), rd);
            apb(1'b0, ring_assist_pkg::VLAN_DATA1_OFS, 32'h0);
            chk("vlan_filtering_id", 32'(v), rd);
        end
        for (int i = 0; i < 256; i++) begin
            apb(1'b1, ring_assist_pkg::MAC_IDX_OFS, 32'(i));
            apb(1'b0, ring_assist_pkg::MAC_DATA_OFS, 32'h0);
            chk("mac entry", 32'((mv[i] << 31) | (mp[i] << 20) | mf[i]), rd);
        end
        apb(1'b0, ring_assist_pkg::FOUND_CNT_OFS, 32'h0);
        chk("found count", 32'(found), rd);
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        apb(1'b0, ring_assist_pkg::CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, ring_assist_pkg::ACCESS_FID_OFS, 32'h0);
        chk("single fid reset", 32'h1ffff, rd);
        apb(1'b0, ring_assist_pkg::LIST_END_OFS, 32'h0);
        chk("list reset", 32'h1ffff, rd);
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int v = 0; v < 64; v++) begin
            grp[v] = rnd() & 3;
            mem[v] = rnd() & 'h7ff;
            apb(1'b1, ring_assist_pkg::VLAN_IDX_OFS, 32'(v));
            apb(1'b1, ring_assist_pkg::VLAN_DATA0_OFS, 32'((mem[v] << 16) | grp[v]));
            apb(1'b1, ring_assist_pkg::VLAN_DATA1_OFS, 32'(v));
        end
        for (int i = 0; i < 256; i++) begin
            mv[i] = rnd() & 1;
            mp[i] = rnd() & 15;
            mf[i] = rnd() % 48;
            apb(1'b1, ring_assist_pkg::MAC_IDX_OFS, 32'(i));
            apb(1'b1, ring_assist_pkg::MAC_DATA_OFS, 32'((mv[i] << 31) | (mp[i] << 20) | mf[i]));
        end
        // Five live slots, the rest left at the reserved value
        foreach (lst[j]) begin
            lst[j] = j < 5 ? rnd() % 48 : 'h1ffff;
            apb(1'b1, 8'(ring_assist_pkg::LIST_BASE_OFS + 4 * j), 32'(lst[j]));
        end
        apb(1'b1, ring_assist_pkg::PORT_FILTER_OFS, 32'h180);
        apb(1'b1, ring_assist_pkg::SELECT_OFS, 32'h0400_0002);
        apb(1'b1, ring_assist_pkg::RANGE_OFS, 32'h0023_000a);
        apb(1'b1, ring_assist_pkg::PORT_SET_OFS, 32'h100);
        apb(1'b1, ring_assist_pkg::CTRL_OFS, 32'hfc);
        apb(1'b1, ring_assist_pkg::CTRL_OFS, 32'hff);
        run('hff, 10, 35, 2, 'h1ffff);
        wt(1'b0);
        wt(1'b1);
        chk("irq raised", 32'h1, {31'h0, o_flush_irq});
        apb(1'b0, ring_assist_pkg::STATUS_OFS, 32'h0);
        chk("status done", 32'h3, rd);
        apb(1'b1, ring_assist_pkg::STATUS_OFS, 32'h3);
        chk("irq cleared", 32'h0, {31'h0, o_flush_irq});
        check_all();
        // Single fid only, selector off, no removal
        apb(1'b1, ring_assist_pkg::ACCESS_FID_OFS, 32'(mf[7]));
        apb(1'b1, ring_assist_pkg::RANGE_OFS, 32'h002d_0028);
        apb(1'b1, ring_assist_pkg::CTRL_OFS, 32'h15);
        run('h15, 40, 45, 0, mf[7]);
        wt(1'b1);
        chk("irq masked", 32'h0, {31'h0, o_flush_irq});
        check_all();
        // Inverted range: nothing visited, go clears at once
        apb(1'b1, ring_assist_pkg::STATUS_OFS, 32'h3);
        apb(1'b1, ring_assist_pkg::RANGE_OFS, 32'h0003_0005);
        apb(1'b1, ring_assist_pkg::CTRL_OFS, 32'h1);
        apb(1'b0, ring_assist_pkg::STATUS_OFS, 32'h0);
        chk("status empty sweep", 32'h2, rd);
        apb(1'b0, ring_assist_pkg::CTRL_OFS, 32'h0);
        chk("go cleared", 32'h0, rd);
        check_all();
        give_verdict();
    end
endmodule

// >>> rtl/fid_list_match.sv
// Compares one filtering ID against the flush list of sixteen values
`timescale 1ns/1ps
module fid_list_match (
    input wire logic [16:0] i_fid,
    input wire logic [ring_assist_pkg::LIST_N-1:0][16:0] i_list,
    output logic o_hit
);
    always_comb begin
        o_hit = 1'b0;
        for (int i = 0; i < ring_assist_pkg::LIST_N; i++) begin
            // Unused slots hold the reserved value and never match
            if (i_list[i] != ring_assist_pkg::FID_UNUSED && i_list[i] == i_fid) begin
                o_hit = 1'b1;
            end
        end
    end
endmodule

// >>> rtl/ring_assist.sv
// VLAN table update engine and MAC table flush engine behind an APB slave
`timescale 1ns/1ps
module ring_assist (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_flush_irq,
    output logic o_update_busy,
    output logic o_flush_busy
);
    typedef enum logic [1:0] {UPD_IDLE = 2'b01, UPD_RUN = 2'b10} upd_state_type;
    typedef enum logic [1:0] {FL_IDLE = 2'b01, FL_SCAN = 2'b10} fl_state_type;

    // Tables
    logic [15:0] vlan_group_q [ring_assist_pkg::VLAN_DEPTH];
    logic [10:0] vlan_member_q [ring_assist_pkg::VLAN_DEPTH];
    logic [16:0] vlan_filtering_id_q [ring_assist_pkg::VLAN_DEPTH];
    logic mac_valid_q [ring_assist_pkg::MAC_DEPTH];
    logic [16:0] mac_fid_q [ring_assist_pkg::MAC_DEPTH];
    logic [3:0] mac_port_q [ring_assist_pkg::MAC_DEPTH];

    // Configuration and status
    logic [7:0] ctrl_q, ctrl_d;
    logic [1:0] stat_q, stat_d;
    logic [15:0] sel_group_q, sel_group_d;
    logic [10:0] sel_member_q, sel_member_d;
    logic [11:0] first_vid_q, first_vid_d, last_vid_q, last_vid_d;
    logic [10:0] port_set_q, port_set_d;
    logic [16:0] access_fid_q, access_fid_d;
    logic [10:0] port_filter_q, port_filter_d;
    logic [15:0] found_cnt_q, found_cnt_d;
    logic [11:0] vlan_idx_q, vlan_idx_d;
    logic [15:0] stage_group_q, stage_group_d;
    logic [10:0] stage_member_q, stage_member_d;
    logic [7:0] mac_idx_q, mac_idx_d;
    logic [ring_assist_pkg::LIST_N-1:0][16:0] list_q, list_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic irq_q, irq_d, upd_busy_q, upd_busy_d, fl_busy_q, fl_busy_d;

    // Engines
    upd_state_type upd_q, upd_d;
    fl_state_type fl_q, fl_d;
    logic [11:0] upd_vid_q, upd_vid_d;
    logic [7:0] fl_idx_q, fl_idx_d;

    // Table write controls
    logic vlan_sw_we, vlan_eng_we, mac_sw_we, mac_eng_clr;
    logic [16:0] sw_fid;
    logic mac_sw_valid;
    logic [3:0] mac_sw_port;
    logic [10:0] upd_new_member;
    logic upd_selected, upd_done, fl_done, fl_match, list_hit;
    logic fid_pass, port_pass;

    logic setup, access, mapped;
    logic [3:0] list_sel;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable & pready_q;
    assign list_sel = i_paddr[5:2];

    fid_list_match u_list (
        .i_fid(mac_fid_q[fl_idx_q]),
        .i_list(list_q),
        .o_hit(list_hit)
    );

    // VLAN update engine datapath
    always_comb begin
        // Group field and member field both act as selectors
        upd_selected = ~ctrl_q[ring_assist_pkg::CTRL_SEL_ENABLE]
            | (|(vlan_group_q[upd_vid_q] & sel_group_q))
            | (|(vlan_member_q[upd_vid_q] & sel_member_q));
        upd_new_member = vlan_member_q[upd_vid_q] | port_set_q;
        upd_done = (upd_q == UPD_RUN) && (upd_vid_q == last_vid_q);
        vlan_eng_we = (upd_q == UPD_RUN) && upd_selected;
        upd_d = upd_q;
        upd_vid_d = upd_vid_q;
        case (upd_q)
            UPD_IDLE: begin
                if (ctrl_q[ring_assist_pkg::CTRL_UPDATE_GO]) begin
                    if (first_vid_q > last_vid_q) begin
                        upd_d = UPD_IDLE;
                    end else begin
                        upd_d = UPD_RUN;
                        upd_vid_d = first_vid_q;
                    end
                end
            end
            UPD_RUN: begin
                if (upd_done) begin
                    upd_d = UPD_IDLE;
                end else begin
                    upd_vid_d = upd_vid_q + 12'h001;
                end
            end
            default: upd_d = UPD_IDLE;
        endcase
    end

    // MAC flush engine datapath
    always_comb begin
        // Single ID counts only when not the reserved value
        fid_pass = ~ctrl_q[ring_assist_pkg::CTRL_FID_FILTER]
            | (ctrl_q[ring_assist_pkg::CTRL_LIST_ENABLE] & list_hit)
            | (access_fid_q != ring_assist_pkg::FID_UNUSED
               && access_fid_q == mac_fid_q[fl_idx_q]);
        port_pass = ~ctrl_q[ring_assist_pkg::CTRL_PORT_FILTER]
            | ((mac_port_q[fl_idx_q] < 4'hb) && port_filter_q[mac_port_q[fl_idx_q]]);
        fl_match = (fl_q == FL_SCAN) && mac_valid_q[fl_idx_q] && fid_pass && port_pass;
        mac_eng_clr = fl_match && ctrl_q[ring_assist_pkg::CTRL_REMOVE];
        fl_done = (fl_q == FL_SCAN) && (fl_idx_q == 8'hff);
        fl_d = fl_q;
        fl_idx_d = fl_idx_q;
        case (fl_q)
            FL_IDLE: begin
                if (ctrl_q[ring_assist_pkg::CTRL_TRIGGER]) begin
                    fl_d = FL_SCAN;
                    fl_idx_d = 8'h00;
                end
            end
            FL_SCAN: begin
                fl_idx_d = fl_idx_q + 8'h01;
                if (fl_done) begin
                    fl_d = FL_IDLE;
                end
            end
            default: fl_d = FL_IDLE;
        endcase
    end

    // Register file and APB slave
    always_comb begin
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        sel_group_d = sel_group_q;
        sel_member_d = sel_member_q;
        first_vid_d = first_vid_q;
        last_vid_d = last_vid_q;
        port_set_d = port_set_q;
        access_fid_d = access_fid_q;
        port_filter_d = port_filter_q;
        found_cnt_d = found_cnt_q;
        vlan_idx_d = vlan_idx_q;
        stage_group_d = stage_group_q;
        stage_member_d = stage_member_q;
        mac_idx_d = mac_idx_q;
        list_d = list_q;
        vlan_sw_we = 1'b0;
        mac_sw_we = 1'b0;
        sw_fid = i_pwdata[16:0];
        mac_sw_valid = i_pwdata[ring_assist_pkg::MAC_VALID_BIT];
        mac_sw_port = i_pwdata[ring_assist_pkg::MAC_PORT_LSB +: 4];
        mapped = 1'b1;
        prdata_d = 32'h0000_0000;
        case (i_paddr)
            ring_assist_pkg::CTRL_OFS: prdata_d = {24'h00_0000, ctrl_q};
            ring_assist_pkg::STATUS_OFS: prdata_d = {30'h0000_0000, stat_q};
            ring_assist_pkg::SELECT_OFS: prdata_d = {5'h00, sel_member_q, sel_group_q};
            ring_assist_pkg::RANGE_OFS: prdata_d = {4'h0, last_vid_q, 4'h0, first_vid_q};
            ring_assist_pkg::PORT_SET_OFS: prdata_d = {21'h00_0000, port_set_q};
            ring_assist_pkg::ACCESS_FID_OFS: prdata_d = {15'h0000, access_fid_q};
            ring_assist_pkg::PORT_FILTER_OFS: prdata_d = {21'h00_0000, port_filter_q};
            ring_assist_pkg::FOUND_CNT_OFS: prdata_d = {16'h0000, found_cnt_q};
            ring_assist_pkg::VLAN_IDX_OFS: prdata_d = {20'h0_0000, vlan_idx_q};
            ring_assist_pkg::VLAN_DATA0_OFS:
                prdata_d = {5'h00, vlan_member_q[vlan_idx_q], vlan_group_q[vlan_idx_q]};
            ring_assist_pkg::VLAN_DATA1_OFS: prdata_d = {15'h0000, vlan_filtering_id_q[vlan_idx_q]};
            ring_assist_pkg::MAC_IDX_OFS: prdata_d = {24'h00_0000, mac_idx_q};
            ring_assist_pkg::MAC_DATA_OFS:
                prdata_d = {mac_valid_q[mac_idx_q], 7'h00, mac_port_q[mac_idx_q],
                            3'h0, mac_fid_q[mac_idx_q]};
            default: begin
                if (i_paddr >= ring_assist_pkg::LIST_BASE_OFS
                        && i_paddr <= ring_assist_pkg::LIST_END_OFS
                        && i_paddr[1:0] == 2'b00) begin
                    prdata_d = {15'h0000, list_q[list_sel]};
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
        if (!setup || i_pwrite) begin
            prdata_d = 32'h0000_0000;
        end
        pready_d = setup;
        pslverr_d = setup & ~mapped;
        if (access && i_pwrite) begin
            case (i_paddr)
                ring_assist_pkg::CTRL_OFS: begin
                    // Go bits only set; clearing is the engines' job
                    ctrl_d[7:3] = i_pwdata[7:3];
                    ctrl_d[ring_assist_pkg::CTRL_SEL_ENABLE] =
                        i_pwdata[ring_assist_pkg::CTRL_SEL_ENABLE];
                    if (i_pwdata[ring_assist_pkg::CTRL_UPDATE_GO]) begin
                        ctrl_d[ring_assist_pkg::CTRL_UPDATE_GO] = 1'b1;
                    end
                    if (i_pwdata[ring_assist_pkg::CTRL_TRIGGER]) begin
                        ctrl_d[ring_assist_pkg::CTRL_TRIGGER] = 1'b1;
                    end
                end
                ring_assist_pkg::STATUS_OFS: stat_d = stat_q & ~i_pwdata[1:0];
                ring_assist_pkg::SELECT_OFS: begin
                    sel_group_d = i_pwdata[15:0];
                    sel_member_d = i_pwdata[ring_assist_pkg::SEL_MEMBER_LSB +: 11];
                end
                ring_assist_pkg::RANGE_OFS: begin
                    first_vid_d = i_pwdata[11:0];
                    last_vid_d = i_pwdata[ring_assist_pkg::RANGE_LAST_LSB +: 12];
                end
                ring_assist_pkg::PORT_SET_OFS: port_set_d = i_pwdata[10:0];
                ring_assist_pkg::ACCESS_FID_OFS: access_fid_d = i_pwdata[16:0];
                ring_assist_pkg::PORT_FILTER_OFS: port_filter_d = i_pwdata[10:0];
                ring_assist_pkg::VLAN_IDX_OFS: vlan_idx_d = i_pwdata[11:0];
                ring_assist_pkg::VLAN_DATA0_OFS: begin
                    stage_group_d = i_pwdata[15:0];
                    stage_member_d = i_pwdata[ring_assist_pkg::SEL_MEMBER_LSB +: 11];
                end
                // Commit is dropped while the sweep runs so the engine never races software
                ring_assist_pkg::VLAN_DATA1_OFS: vlan_sw_we = (upd_q == UPD_IDLE);
                ring_assist_pkg::MAC_IDX_OFS: mac_idx_d = i_pwdata[7:0];
                ring_assist_pkg::MAC_DATA_OFS: mac_sw_we = (fl_q == FL_IDLE);
                default: begin
                    if (i_paddr >= ring_assist_pkg::LIST_BASE_OFS
                            && i_paddr <= ring_assist_pkg::LIST_END_OFS
                            && i_paddr[1:0] == 2'b00) begin
                        list_d[list_sel] = i_pwdata[16:0];
                    end
                end
            endcase
        end
        if (ctrl_q[ring_assist_pkg::CTRL_TRIGGER] && fl_q == FL_IDLE) begin
            found_cnt_d = 16'h0000;
        end else if (fl_match) begin
            found_cnt_d = found_cnt_q + 16'h0001;
        end
        // Completion set beats a same-cycle software clear
        if (upd_done || (upd_q == UPD_IDLE && ctrl_q[ring_assist_pkg::CTRL_UPDATE_GO]
                         && first_vid_q > last_vid_q)) begin
            ctrl_d[ring_assist_pkg::CTRL_UPDATE_GO] = 1'b0;
            stat_d[ring_assist_pkg::STAT_UPDATE_DONE] = 1'b1;
        end
        if (fl_done) begin
            ctrl_d[ring_assist_pkg::CTRL_TRIGGER] = 1'b0;
            stat_d[ring_assist_pkg::STAT_FLUSH_DONE] = 1'b1;
        end
        irq_d = stat_d[ring_assist_pkg::STAT_FLUSH_DONE]
            & ctrl_d[ring_assist_pkg::CTRL_IRQ_ENABLE];
        // Independent engines: both may be busy at once
        upd_busy_d = ctrl_d[ring_assist_pkg::CTRL_UPDATE_GO];
        fl_busy_d = ctrl_d[ring_assist_pkg::CTRL_TRIGGER];
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= ring_assist_pkg::CTRL_RST;
            stat_q <= 2'b00;
            sel_group_q <= 16'h0000;
            sel_member_q <= 11'h000;
            first_vid_q <= 12'h000;
            last_vid_q <= 12'h000;
            port_set_q <= 11'h000;
            access_fid_q <= ring_assist_pkg::ACCESS_FID_RST;
            port_filter_q <= 11'h000;
            found_cnt_q <= 16'h0000;
            vlan_idx_q <= 12'h000;
            stage_group_q <= 16'h0000;
            stage_member_q <= 11'h000;
            mac_idx_q <= 8'h00;
            list_q <= {ring_assist_pkg::LIST_N{ring_assist_pkg::LIST_RST}};
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            upd_busy_q <= 1'b0;
            fl_busy_q <= 1'b0;
            upd_q <= UPD_IDLE;
            fl_q <= FL_IDLE;
            upd_vid_q <= 12'h000;
            fl_idx_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            sel_group_q <= sel_group_d;
            sel_member_q <= sel_member_d;
            first_vid_q <= first_vid_d;
            last_vid_q <= last_vid_d;
            port_set_q <= port_set_d;
            access_fid_q <= access_fid_d;
            port_filter_q <= port_filter_d;
            found_cnt_q <= found_cnt_d;
            vlan_idx_q <= vlan_idx_d;
            stage_group_q <= stage_group_d;
            stage_member_q <= stage_member_d;
            mac_idx_q <= mac_idx_d;
            list_q <= list_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            upd_busy_q <= upd_busy_d;
            fl_busy_q <= fl_busy_d;
            upd_q <= upd_d;
            fl_q <= fl_d;
            upd_vid_q <= upd_vid_d;
            fl_idx_q <= fl_idx_d;
        end
    end

    // Table storage; no reset so it maps to plain memory
    always_ff @(posedge i_mclk) begin
        if (vlan_sw_we) begin
            vlan_group_q[vlan_idx_q] <= stage_group_q;
            vlan_member_q[vlan_idx_q] <= stage_member_q;
            vlan_filtering_id_q[vlan_idx_q] <= sw_fid;
        end else if (vlan_eng_we) begin
            vlan_member_q[upd_vid_q] <= upd_new_member;
        end
        if (mac_sw_we) begin
            mac_valid_q[mac_idx_q] <= mac_sw_valid;
            mac_fid_q[mac_idx_q] <= sw_fid;
            mac_port_q[mac_idx_q] <= mac_sw_port;
        end else if (mac_eng_clr) begin
            mac_valid_q[fl_idx_q] <= 1'b0;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_flush_irq = irq_q;
    assign o_update_busy = upd_busy_q;
    assign o_flush_busy = fl_busy_q;
endmodule

// >>> shared/ring_assist_pkg.sv
// Constants for the ring protection assist block: register map, fields, resets
package ring_assist_pkg;
    // Table geometry
    localparam int VID_W = 12;
    localparam int VLAN_DEPTH = 4096;
    localparam int GROUP_W = 16;
    localparam int MEMBER_W = 11;
    localparam int FID_W = 17;
    localparam int LIST_N = 16;
    localparam int MAC_IDX_W = 8;
    localparam int MAC_DEPTH = 256;
    localparam int PORT_W = 4;
    localparam int COUNT_W = 16;

    // Reserved filtering ID marking an unused value
    localparam logic [16:0] FID_UNUSED = 17'h1ffff;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] SELECT_OFS = 8'h08;
    localparam logic [7:0] RANGE_OFS = 8'h0c;
    localparam logic [7:0] PORT_SET_OFS = 8'h10;
    localparam logic [7:0] ACCESS_FID_OFS = 8'h14;
    localparam logic [7:0] PORT_FILTER_OFS = 8'h18;
    localparam logic [7:0] FOUND_CNT_OFS = 8'h1c;
    localparam logic [7:0] VLAN_IDX_OFS = 8'h20;
    localparam logic [7:0] VLAN_DATA0_OFS = 8'h24;
    localparam logic [7:0] VLAN_DATA1_OFS = 8'h28;
    localparam logic [7:0] MAC_IDX_OFS = 8'h30;
    localparam logic [7:0] MAC_DATA_OFS = 8'h34;
    localparam logic [7:0] LIST_BASE_OFS = 8'h40;
    localparam logic [7:0] LIST_END_OFS = 8'h7c;

    // CTRL bit positions
    localparam int CTRL_UPDATE_GO = 0;
    localparam int CTRL_SEL_ENABLE = 1;
    localparam int CTRL_TRIGGER = 2;
    localparam int CTRL_LIST_ENABLE = 3;
    localparam int CTRL_FID_FILTER = 4;
    localparam int CTRL_PORT_FILTER = 5;
    localparam int CTRL_REMOVE = 6;
    localparam int CTRL_IRQ_ENABLE = 7;

    // STATUS bit positions
    localparam int STAT_FLUSH_DONE = 0;
    localparam int STAT_UPDATE_DONE = 1;

    // Field positions
    localparam int SEL_MEMBER_LSB = 16;
    localparam int RANGE_LAST_LSB = 16;
    localparam int MAC_PORT_LSB = 20;
    localparam int MAC_VALID_BIT = 31;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [16:0] ACCESS_FID_RST = 17'h1ffff;
    localparam logic [16:0] LIST_RST = 17'h1ffff;
endpackage
